// >>> hdl/pci_defines.svh
// register map, field positions, reset values and bus codes of the pin change block
`ifndef PCI_DEFINES_SVH
`define PCI_DEFINES_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PCI_NPIN 6
`define PCI_ADDR_W 8
`define PCI_REG_W 8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PCI_OFF_RISE 8'h00
`define PCI_OFF_FALL 8'h04
`define PCI_OFF_FLAG 8'h08
`define PCI_OFF_IRQCTL 8'h0C
`define PCI_OFF_IRQSTAT 8'h10
`define PCI_OFF_IRQMASK 8'h14

// ----------------------------------------------------------------
// field positions in the irq control register
// ----------------------------------------------------------------
`define PCI_IRQCTL_MEN_BIT 3
`define PCI_IRQCTL_SUM_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PCI_RST_RISE 6'h00
`define PCI_RST_FALL 6'h00
`define PCI_RST_FLAG 6'h00
`define PCI_RST_MEN 1'h0
`define PCI_RST_IRQSTAT 6'h00
`define PCI_RST_IRQMASK 6'h00

// ----------------------------------------------------------------
// bus response codes
// ----------------------------------------------------------------
`define PCI_RESP_OKAY 2'h0
`define PCI_RESP_SLVERR 2'h2

`endif

// >>> hdl/pci_edge_det.sv
// per-pin synchroniser and qualified edge detector
`include "pci_defines.svh"

module pci_edge_det #(
    parameter int NPIN = `PCI_NPIN
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // pins and enables
    input wire logic [NPIN-1:0] pin_async,
    input wire logic [NPIN-1:0] rise_en,
    input wire logic [NPIN-1:0] fall_en,
    // results
    output logic [NPIN-1:0] pin_level,
    output logic [NPIN-1:0] edge_hit
);

    // ----------------------------------------------------------------
    // one detector per pin
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic meta_q;
            logic sync_q;
            logic prev_q;
            wire rise_seen;
            wire fall_seen;

            // first stage only feeds the second
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else if (ce) begin
                    meta_q <= pin_async[gi];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign rise_seen = sync_q & ~prev_q; // R14
            assign fall_seen = ~sync_q & prev_q; // R14
            // a pin with both enables low can never hit
            assign edge_hit[gi] = ce & ((rise_en[gi] & rise_seen) | (fall_en[gi] & fall_seen)); // R03 R04 R05
            assign pin_level[gi] = sync_q;
        end
    endgenerate

endmodule : pci_edge_det

// >>> hdl/pci_pkg.sv
// types shared by the pin change block
`include "pci_defines.svh"

package pci_pkg;

    // ----------------------------------------------------------------
    // control set written by software
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`PCI_NPIN-1:0] rise;
        logic [`PCI_NPIN-1:0] fall;
        logic master_en;
    } pci_ctrl_t;

    // ----------------------------------------------------------------
    // one captured bus write
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`PCI_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pci_wr_t;

    // ----------------------------------------------------------------
    // write channel states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PCI_WS_COLLECT = 2'b01,
        PCI_WS_RESP = 2'b10
    } pci_wstate_t;

endpackage : pci_pkg

// >>> hdl/pci_top.sv
// pin change interrupt block with its AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`include "pci_defines.svh"

// How it works
// (R01) enabled edge wakes sleeping core via interrupt
// (R02) sleep edges land in flags before wake
// (R03) low six bits enable rising-edge flag setting
// (R04) low six bits enable falling-edge flag setting
// (R05) both enables clear means flag never sets
// (R06) flag sets on enabled matching edge
// (R07) flag sticks until software writes zero
// (R08) top two bits of control registers read zero
// (R09) hardware sets flags independent of software access
// (R10) software clears with xor then and sequence
// (R11) master enable off still detects, no interrupt
// (R12) summary flag shows any pin flag set
// (R13) edge during flag write leaves flag set
// (R14) pins synchronised, edge from two samples
// (R15) enables and flags reset to zero
module pci_top #(
    parameter int NPIN = `PCI_NPIN
) (
    // clock, reset and freeze
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write address channel
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`PCI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // write data channel
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // write response channel
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // read address channel
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`PCI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // read data channel
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // port pins and core state
    input wire logic [NPIN-1:0] port_pin_n,
    input wire logic sleep_state,
    // interrupt and wake
    output logic irq,
    output logic wake_req,
    output logic change_irq_summary_flag
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pci_pkg::pci_ctrl_t ctrl_q;
    pci_pkg::pci_ctrl_t ctrl_d;
    logic [NPIN-1:0] pin_change_flag_q;
    logic [NPIN-1:0] pin_change_flag_d;
    logic [NPIN-1:0] irq_stat_q;
    logic [NPIN-1:0] irq_stat_d;
    logic [NPIN-1:0] irq_mask_q;
    logic [NPIN-1:0] irq_mask_d;

    // ----------------------------------------------------------------
    // write channel state
    // ----------------------------------------------------------------
    // two hold flags let address and data arrive in either order
    pci_pkg::pci_wstate_t wstate_q;
    pci_pkg::pci_wstate_t wstate_d;
    pci_pkg::pci_wr_t wr_q;
    pci_pkg::pci_wr_t wr_d;
    logic aw_full_q;
    logic aw_full_d;
    logic w_full_q;
    logic w_full_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;

    // one read slot: arready stays low until the answer is taken
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // irq and the summary flag leave flip-flops rather than the gates behind them
    logic irq_q;
    logic summary_q;

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    // the detector is the only reader of the raw pins
    wire [NPIN-1:0] edge_hit;
    wire [NPIN-1:0] pin_level;

    pci_edge_det #(
        .NPIN(NPIN)
    ) u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_async(port_pin_n),
        .rise_en(ctrl_q.rise),
        .fall_en(ctrl_q.fall),
        .pin_level(pin_level),
        .edge_hit(edge_hit)
    );

    // ----------------------------------------------------------------
    // write channel handshakes
    // ----------------------------------------------------------------
    // each channel is taken on its own; the pair commits once both are held
    wire in_collect = (wstate_q == pci_pkg::PCI_WS_COLLECT);
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire wr_commit = ce & in_collect & aw_full_q & w_full_q;
    wire b_done = ce & s_axi_bvalid & s_axi_bready;

    assign s_axi_awready = ce & in_collect & ~aw_full_q;
    assign s_axi_wready = ce & in_collect & ~w_full_q;
    assign s_axi_bvalid = (wstate_q == pci_pkg::PCI_WS_RESP);
    assign s_axi_bresp = bresp_q;

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    wire [`PCI_ADDR_W-1:0] wr_word = {wr_q.addr[`PCI_ADDR_W-1:2], 2'b00};
    wire lane0 = wr_q.strb[0];
    wire [NPIN-1:0] wr_bits = wr_q.data[NPIN-1:0];

    wire wsel_rise = (wr_word == `PCI_OFF_RISE);
    wire wsel_fall = (wr_word == `PCI_OFF_FALL);
    wire wsel_flag = (wr_word == `PCI_OFF_FLAG);
    wire wsel_ctl = (wr_word == `PCI_OFF_IRQCTL);
    wire wsel_stat = (wr_word == `PCI_OFF_IRQSTAT);
    wire wsel_mask = (wr_word == `PCI_OFF_IRQMASK);

    wire wsel_any = wsel_rise | wsel_fall | wsel_flag | wsel_ctl | wsel_stat | wsel_mask;

    // a write with lane zero off is answered but changes nothing
    wire wr_en = wr_commit & lane0;
    wire wr_rise = wr_en & wsel_rise;
    wire wr_fall = wr_en & wsel_fall;
    wire wr_flag = wr_en & wsel_flag;
    wire wr_ctl = wr_en & wsel_ctl;
    wire wr_stat = wr_en & wsel_stat;
    wire wr_mask = wr_en & wsel_mask;

    // ----------------------------------------------------------------
    // next values of the write path
    // ----------------------------------------------------------------
    always_comb begin
        wstate_d = wstate_q;
        wr_d = wr_q;
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        bresp_d = bresp_q;

        if (aw_take) begin
            wr_d.addr = s_axi_awaddr;
            aw_full_d = 1'b1;
        end
        if (w_take) begin
            wr_d.data = s_axi_wdata;
            wr_d.strb = s_axi_wstrb;
            w_full_d = 1'b1;
        end

        case (wstate_q)
            pci_pkg::PCI_WS_COLLECT: begin
                if (wr_commit) begin
                    aw_full_d = 1'b0;
                    w_full_d = 1'b0;
                    bresp_d = wsel_any ? `PCI_RESP_OKAY : `PCI_RESP_SLVERR;
                    wstate_d = pci_pkg::PCI_WS_RESP;
                end
            end
            pci_pkg::PCI_WS_RESP: begin
                if (b_done) begin
                    wstate_d = pci_pkg::PCI_WS_COLLECT;
                end
            end
            default: begin
                wstate_d = pci_pkg::PCI_WS_COLLECT;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_q <= pci_pkg::PCI_WS_COLLECT;
            wr_q <= '0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bresp_q <= `PCI_RESP_OKAY;
        end else if (ce) begin
            wstate_q <= wstate_d;
            wr_q <= wr_d;
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            bresp_q <= bresp_d;
        end
    end

    // ----------------------------------------------------------------
    // control and flag registers
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_rise) begin
            ctrl_d.rise = wr_bits; // R03
        end
        if (wr_fall) begin
            ctrl_d.fall = wr_bits; // R04
        end
        if (wr_ctl) begin
            ctrl_d.master_en = wr_q.data[`PCI_IRQCTL_MEN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // flag and status next values
    // ----------------------------------------------------------------
    // a set arriving with a software write wins over the written value
    always_comb begin
        pin_change_flag_d = wr_flag ? wr_bits : pin_change_flag_q; // R07 R10
        pin_change_flag_d = pin_change_flag_d | edge_hit; // R06 R09 R13
        irq_stat_d = wr_stat ? (irq_stat_q & ~wr_bits) : irq_stat_q;
        irq_stat_d = irq_stat_d | edge_hit;
        irq_mask_d = wr_mask ? wr_bits : irq_mask_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q.rise <= `PCI_RST_RISE; // R15
            ctrl_q.fall <= `PCI_RST_FALL; // R15
            ctrl_q.master_en <= `PCI_RST_MEN;
            pin_change_flag_q <= `PCI_RST_FLAG; // R15
            irq_stat_q <= `PCI_RST_IRQSTAT;
            irq_mask_q <= `PCI_RST_IRQMASK;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            pin_change_flag_q <= pin_change_flag_d; // R02
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    // ----------------------------------------------------------------
    // interrupt, summary and wake
    // ----------------------------------------------------------------
    // detection keeps running with the master enable off; only the output is held
    wire flag_any = |pin_change_flag_q; // R12
    wire summary_d = |pin_change_flag_d; // R12
    wire irq_d = ctrl_d.master_en & (|(irq_stat_d & irq_mask_d)); // R11

    // built from next values, so they move at the same edge as the registers behind them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'h0;
            summary_q <= 1'h0;
        end else if (ce) begin
            irq_q <= irq_d;
            summary_q <= summary_d;
        end
    end

    assign change_irq_summary_flag = summary_q; // R12
    assign irq = irq_q; // R11
    // wake follows the registered irq, which rises at the edge that sets the flag, so the flag is already set when the core runs
    assign wake_req = sleep_state & irq; // R01 R02

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    wire [`PCI_ADDR_W-1:0] rd_word = {s_axi_araddr[`PCI_ADDR_W-1:2], 2'b00};

    wire rsel_rise = (rd_word == `PCI_OFF_RISE);
    wire rsel_fall = (rd_word == `PCI_OFF_FALL);
    wire rsel_flag = (rd_word == `PCI_OFF_FLAG);
    wire rsel_ctl = (rd_word == `PCI_OFF_IRQCTL);
    wire rsel_stat = (rd_word == `PCI_OFF_IRQSTAT);
    wire rsel_mask = (rd_word == `PCI_OFF_IRQMASK);

    wire rsel_any = rsel_rise | rsel_fall | rsel_flag | rsel_ctl | rsel_stat | rsel_mask;
    // the answer is registered at the edge that takes the address
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_done = ce & s_axi_rvalid & s_axi_rready;

    // ----------------------------------------------------------------
    // read data select
    // ----------------------------------------------------------------
    // unused upper bits stay zero through the zero extension
    wire [31:0] rd_rise = 32'(ctrl_q.rise); // R08
    wire [31:0] rd_fall = 32'(ctrl_q.fall); // R08
    wire [31:0] rd_flag = 32'(pin_change_flag_q); // R08
    wire [31:0] rd_stat = 32'(irq_stat_q);
    wire [31:0] rd_mask = 32'(irq_mask_q);
    wire [31:0] rd_ctl = (32'(ctrl_q.master_en) << `PCI_IRQCTL_MEN_BIT)
                       | (32'(flag_any) << `PCI_IRQCTL_SUM_BIT);

    wire [31:0] rd_mux = ({32{rsel_rise}} & rd_rise)
                       | ({32{rsel_fall}} & rd_fall)
                       | ({32{rsel_flag}} & rd_flag)
                       | ({32{rsel_ctl}} & rd_ctl)
                       | ({32{rsel_stat}} & rd_stat)
                       | ({32{rsel_mask}} & rd_mask);

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = ce & ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= `PCI_RESP_OKAY;
        end else if (ce) begin
            if (ar_take) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= rsel_any ? `PCI_RESP_OKAY : `PCI_RESP_SLVERR;
            end else if (r_done) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // inputs that only shape nothing here
    // ----------------------------------------------------------------
    // protection bits are accepted and ignored; the pin levels are kept for debug taps
    wire unused_ok = &{1'b0, s_axi_awprot, s_axi_arprot, pin_level, wr_q.data[31:8]};

endmodule : pci_top

// >>> testbench/pci_checker.sv
// port checker of the pin change block
`include "pci_defines.svh"

module pci_checker #(
    parameter int NPIN = `PCI_NPIN
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [`PCI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // pins and events
    input wire logic [NPIN-1:0] port_pin_n,
    input wire logic sleep_state,
    input wire logic irq,
    input wire logic wake_req,
    input wire logic change_irq_summary_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------
    // properties
    // ------
    a_wake_level: assert property (wake_req == (sleep_state && irq))
        else $error("wake request not equal to sleep and irq");
    a_rdata_top_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0)
        else $error("unimplemented read bits not zero");
    // a write also sets flags, so a bus response excuses a rise
    a_flag_rise_cause: assert property ($rose(change_irq_summary_flag) |-> s_axi_bvalid || $past(port_pin_n, 3) != $past(port_pin_n, 4))
        else $error("flag rose without pin edge or write");
    a_flag_sticky: assert property ($fell(change_irq_summary_flag) |-> s_axi_bvalid)
        else $error("flag fell without a write");
    a_irq_rise_cause: assert property ($rose(irq) |-> s_axi_bvalid || $past(port_pin_n, 3) != $past(port_pin_n, 4))
        else $error("irq rose without pin edge or write");
    a_irq_fall_write: assert property ($fell(irq) |-> s_axi_bvalid)
        else $error("irq fell without a write");
    a_flag_read_sum: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h02 |=> (|s_axi_rdata[5:0]) == $past(change_irq_summary_flag))
        else $error("flag read disagrees with summary");
    a_ctl_read_bits: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h03 |=> s_axi_rdata[0] == $past(change_irq_summary_flag) && s_axi_rdata[2:1] == 2'h0)
        else $error("control read summary bit wrong");
endmodule : pci_checker

// >>> testbench/pci_pin_model.sv
// far-side pin driver of the pin change block
module pci_pin_model (
    // clock
    input wire logic aclk,
    // requested levels and lag select
    input wire logic [5:0] level,
    input wire logic lag,
    // driven pins
    output logic [5:0] port_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] level_q;
    // a lagging pin moves one clock late, as a slow external source would
    always_ff @(posedge aclk) level_q <= level;
    assign port_pin_n = lag ? level_q : level;
endmodule : pci_pin_model

// >>> testbench/pin_change_interrupt_tb_top.sv
// self-checking bench of the pin change block
`include "pci_defines.svh"

module pin_change_interrupt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NPIN = `PCI_NPIN;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1, sleep_state = 1'h0, lag = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, wake_req, change_irq_summary_flag;
    logic [5:0] level = 6'h00, port_pin_n;
    int bad_count = 0, checks = 0, cyc = 0;

    always #2.5 aclk = ~aclk;

    pci_top #(.NPIN(NPIN)) i_dut (
        .aclk, .aresetn, .ce,
        .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
        .port_pin_n, .sleep_state, .irq, .wake_req, .change_irq_summary_flag
    );
    pci_pin_model i_pins (.aclk, .level, .lag, .port_pin_n);

    // ------
    // helpers
    // ------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [5:0] hits(input logic [5:0] o, n, r, f);
        return (n & ~o & r) | (~n & o & f);
    endfunction : hits

    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    // handshakes are judged mid-cycle, where readies have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid & s_axi_awready;
            w_ok = s_axi_wvalid & s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'h0;
            if (w_ok) s_axi_wvalid <= 1'h0;
        end while (!b_ok);
        chk_word("write resp", {30'h0, er}, {30'h0, r});
    endtask : wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid & s_axi_arready;
            r_ok = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'h0;
        end while (!r_ok);
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk_word("read data", e, d);
        chk_word("read resp", {30'h0, er}, {30'h0, r});
    endtask : rd_chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // ------
    // main sequence
    // ------
    initial begin
        logic [31:0] rnd, d;
        logic [5:0] re, fe, mk, nw, old, ex;
        logic [1:0] r;
        rnd = 32'h00012163;
        old = 6'h00;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int a = 0; a < 24; a += 4) rd_chk(8'(a), 32'h0, 2'h0);
        rd_chk(8'h18, 32'h0, `PCI_RESP_SLVERR);
        wr(8'h1C, 32'hFFFFFFFF, `PCI_RESP_SLVERR);
        // lane zero off: answered, nothing stored
        s_axi_wstrb <= 4'hE;
        wr(`PCI_OFF_RISE, 32'h3F, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd_chk(`PCI_OFF_RISE, 32'h0, 2'h0);
        // clock enable low must hold awready and arready low
        ce <= 1'h0;
        @(negedge aclk);
        chk_bit("awready frozen", 1'h0, s_axi_awready);
        chk_bit("arready frozen", 1'h0, s_axi_arready);
        @(posedge aclk);
        ce <= 1'h1;
        wr(`PCI_OFF_IRQCTL, 32'hFFFFFFFF, 2'h0);
        rd_chk(`PCI_OFF_IRQCTL, 32'h8, 2'h0);
        // first two passes are the all-off and all-on corners
        for (int i = 0; i < 24; i++) begin
            repeat (16) rnd = lfsr(rnd);
            re = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : rnd[5:0];
            fe = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : rnd[11:6];
            mk = rnd[17:12];
            nw = rnd[23:18];
            wr(`PCI_OFF_RISE, {~rnd[31:6], re}, 2'h0);
            rd_chk(`PCI_OFF_RISE, {26'h0, re}, 2'h0);
            wr(`PCI_OFF_FALL, {rnd[31:6], fe}, 2'h0);
            wr(`PCI_OFF_FLAG, 32'h0, 2'h0);
            wr(`PCI_OFF_IRQSTAT, 32'h3F, 2'h0);
            wr(`PCI_OFF_IRQMASK, {26'h0, mk}, 2'h0);
            wr(`PCI_OFF_IRQCTL, {28'h0, rnd[24], 3'h0}, 2'h0);
            lag <= rnd[25];
            level <= nw;
            repeat (6) @(posedge aclk);
            ex = hits(old, nw, re, fe);
            rd_chk(`PCI_OFF_FLAG, {26'h0, ex}, 2'h0);
            @(negedge aclk);
            chk_bit("summary", |ex, change_irq_summary_flag);
            chk_bit("irq", rnd[24] & |(ex & mk), irq);
            old = nw;
            @(posedge aclk);
        end
        wr(`PCI_OFF_RISE, 32'h3F, 2'h0);
        wr(`PCI_OFF_FALL, 32'h0, 2'h0);
        wr(`PCI_OFF_IRQMASK, 32'h3F, 2'h0);
        wr(`PCI_OFF_IRQCTL, 32'h8, 2'h0);
        lag <= 1'h0;
        level <= 6'h00;
        repeat (6) @(posedge aclk);
        wr(`PCI_OFF_FLAG, 32'h0, 2'h0);
        wr(`PCI_OFF_IRQSTAT, 32'h3F, 2'h0);
        sleep_state <= 1'h1;
        level <= 6'h01;
        for (int n = 0; n < 10 && wake_req !== 1'h1; n++) @(negedge aclk);
        chk_bit("wake", 1'h1, wake_req);
        chk_bit("flag at wake", 1'h1, change_irq_summary_flag);
        @(posedge aclk);
        sleep_state <= 1'h0;
        wr(`PCI_OFF_FLAG, 32'h0, 2'h0);
        // edges land on the very edge that commits the clearing write
        level <= 6'h3F;
        @(posedge aclk);
        wr(`PCI_OFF_FLAG, 32'h0, 2'h0);
        rd_chk(`PCI_OFF_FLAG, 32'h3E, 2'h0);
        axi_rd(`PCI_OFF_FLAG, d, r);
        wr(`PCI_OFF_FLAG, d & (d ^ 32'hFF), 2'h0);
        rd_chk(`PCI_OFF_FLAG, 32'h0, 2'h0);
        give_verdict();
    end
endmodule : pin_change_interrupt_tb_top

bind pci_top pci_checker #(.NPIN(NPIN)) i_chk (
    .aclk, .aresetn, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rdata, .port_pin_n, .sleep_state, .irq, .wake_req,
    .change_irq_summary_flag
);
